/* core/pabfs_regs.svh */
// Register offsets, field positions and reset values of the port A/B function select block.
// How it works
// [RL1] Port A line 2: codes 00-10 I/O+ext_interrupt_one, 11 LCD2.
// [RL2] Port A line 1: I/O+ext_interrupt_zero, 10 serial out, 11 LCD1.
// [RL3] Port A line 0: I/O, 10 timer out, 11 LCD0.
// [RL4] Port B line 3: I/O, compact timer, LCD11, analog7.
// [RL5] Port B line 2: I/O+timer clock, timer, LCD10, analog2.
// [RL6] Port B line 1: I/O+ext_interrupt_one, LCD9, analog1, crystal two.
// [RL7] Port B line 0: I/O+ext_interrupt_zero, 01 LCD8, rest I/O+ext_interrupt_zero.
// [RL8] All fields read/write, reset to 00.
// [RL9] Software sets direction input for shared inputs.
// [RL10] Software disables peripheral before reselecting pin.
`ifndef PABFS_REGS_SVH
`define PABFS_REGS_SVH
`define PABFS_OFF_PA_LOW 12'h000
`define PABFS_OFF_PA_HIGH 12'h004
`define PABFS_OFF_PB_LOW 12'h008
`define PABFS_RESET_VALUE 8'h00
`define PABFS_FLD_LINE0 1:0
`define PABFS_FLD_LINE1 3:2
`define PABFS_FLD_LINE2 5:4
`define PABFS_FLD_LINE3 7:6
`endif

/* core/pabfs_pkg.sv */
// Types of the port A/B function select block.
package pabfs_pkg;
	typedef enum logic [3:0] {
		PABFS_FN_GPIO,
		PABFS_FN_GPIO_EXT_INTERRUPT_ZERO,
		PABFS_FN_GPIO_EXT_INTERRUPT_ONE,
		PABFS_FN_GPIO_TCK,
		PABFS_FN_STD_TIMER,
		PABFS_FN_CMP_TIMER,
		PABFS_FN_SERIAL_OUT,
		PABFS_FN_LCD,
		PABFS_FN_ANALOG,
		PABFS_FN_CRYSTAL
	} pabfs_func_t;
	typedef struct packed {
		logic [11:0] paddr;
		logic pwrite;
		logic [31:0] pwdata;
	} pabfs_apb_req_t;
	typedef struct packed {
		pabfs_func_t func;
		logic [3:0] lcd_line;
		logic [2:0] analog_chan;
	} pabfs_pin_sel_t;
endpackage

/* core/pabfs_field_reg.sv */
// One software-written 8-bit selection register.
`timescale 1ns/10ps
`default_nettype none
`include "pabfs_regs.svh"
module pabfs_field_reg (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	output logic [7:0] value
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value <= `PABFS_RESET_VALUE; // RL8
		end else if (wr_en) begin
			value <= wr_data;
		end
	end
endmodule
`default_nettype wire

/* core/pabfs_decode.sv */
// Decodes one 2-bit selection field into a pin function for a given pin.
`timescale 1ns/10ps
`default_nettype none
module pabfs_decode #(
	parameter logic [2:0] PIN = 3'h0
) (
	input wire logic [1:0] code,
	output pabfs_pkg::pabfs_pin_sel_t sel
);
	import pabfs_pkg::*;
	always_comb begin
		sel = '{func: PABFS_FN_GPIO, lcd_line: 4'h0, analog_chan: 3'h0};
		case (PIN)
			3'h0: begin
				if (code == 2'h2) sel.func = PABFS_FN_STD_TIMER; // RL3
				else if (code == 2'h3) sel = '{PABFS_FN_LCD, 4'h0, 3'h0}; // RL3
			end
			3'h1: begin
				if (code == 2'h2) sel.func = PABFS_FN_SERIAL_OUT; // RL2
				else if (code == 2'h3) sel = '{PABFS_FN_LCD, 4'h1, 3'h0}; // RL2
				else sel.func = PABFS_FN_GPIO_EXT_INTERRUPT_ZERO; // RL2
			end
			3'h2: begin
				if (code == 2'h3) sel = '{PABFS_FN_LCD, 4'h2, 3'h0}; // RL1
				else sel.func = PABFS_FN_GPIO_EXT_INTERRUPT_ONE; // RL1
			end
			3'h3: begin
				case (code)
					2'h1: sel.func = PABFS_FN_CMP_TIMER; // RL4
					2'h2: sel = '{PABFS_FN_LCD, 4'hB, 3'h0}; // RL4
					2'h3: sel = '{PABFS_FN_ANALOG, 4'h0, 3'h7}; // RL4
					default: sel.func = PABFS_FN_GPIO;
				endcase
			end
			3'h4: begin
				case (code)
					2'h1: sel.func = PABFS_FN_STD_TIMER; // RL5
					2'h2: sel = '{PABFS_FN_LCD, 4'hA, 3'h0}; // RL5
					2'h3: sel = '{PABFS_FN_ANALOG, 4'h0, 3'h2}; // RL5
					default: sel.func = PABFS_FN_GPIO_TCK; // RL5
				endcase
			end
			3'h5: begin
				case (code)
					2'h1: sel = '{PABFS_FN_LCD, 4'h9, 3'h0}; // RL6
					2'h2: sel = '{PABFS_FN_ANALOG, 4'h0, 3'h1}; // RL6
					2'h3: sel.func = PABFS_FN_CRYSTAL; // RL6
					default: sel.func = PABFS_FN_GPIO_EXT_INTERRUPT_ONE; // RL6
				endcase
			end
			3'h6: begin
				if (code == 2'h1) sel = '{PABFS_FN_LCD, 4'h8, 3'h0}; // RL7
				else sel.func = PABFS_FN_GPIO_EXT_INTERRUPT_ZERO; // RL7
			end
			default: sel.func = PABFS_FN_GPIO;
		endcase
	end
endmodule
`default_nettype wire

/* core/pabfs_top.sv */
// APB register block and pin function routing for port A lines 0-2 and port B lines 0-3.
`timescale 1ns/10ps
`default_nettype none
`include "pabfs_regs.svh"
module pabfs_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output pabfs_pkg::pabfs_pin_sel_t port_a_line_0_sel,
	output pabfs_pkg::pabfs_pin_sel_t port_a_line_1_sel,
	output pabfs_pkg::pabfs_pin_sel_t port_a_line_2_sel,
	output pabfs_pkg::pabfs_pin_sel_t port_b_line_0_sel,
	output pabfs_pkg::pabfs_pin_sel_t port_b_line_1_sel,
	output pabfs_pkg::pabfs_pin_sel_t port_b_line_2_sel,
	output pabfs_pkg::pabfs_pin_sel_t port_b_line_3_sel
);
	import pabfs_pkg::*;
	localparam pabfs_pin_sel_t SEL_RESET = '{func: PABFS_FN_GPIO, lcd_line: 4'h0, analog_chan: 3'h0};

	logic [7:0] pa_low_reg;
	logic [7:0] pa_high_reg;
	logic [7:0] pb_low_reg;
	pabfs_apb_req_t req;
	wire logic access_ph;
	wire logic hit_pa_low;
	wire logic hit_pa_high;
	wire logic hit_pb_low;
	wire logic mapped;
	wire logic [31:0] rd_mux;
	pabfs_pin_sel_t dec [0:6];
	wire logic [13:0] codes;

	assign req = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};
	assign access_ph = psel && penable;
	assign hit_pa_low = req.paddr == `PABFS_OFF_PA_LOW;
	assign hit_pa_high = req.paddr == `PABFS_OFF_PA_HIGH;
	assign hit_pb_low = req.paddr == `PABFS_OFF_PB_LOW;
	assign mapped = hit_pa_low || hit_pa_high || hit_pb_low;
	assign rd_mux = hit_pa_low ? {24'h000000, pa_low_reg} :
		hit_pa_high ? {24'h000000, pa_high_reg} :
		hit_pb_low ? {24'h000000, pb_low_reg} : 32'h00000000; // RL8

	pabfs_field_reg u_pa_low (
		.pclk(pclk), .presetn(presetn),
		.wr_en(access_ph && req.pwrite && hit_pa_low), // RL8
		.wr_data(req.pwdata[7:0]), .value(pa_low_reg)
	);
	pabfs_field_reg u_pa_high (
		.pclk(pclk), .presetn(presetn),
		.wr_en(access_ph && req.pwrite && hit_pa_high), // RL8
		.wr_data(req.pwdata[7:0]), .value(pa_high_reg)
	);
	pabfs_field_reg u_pb_low (
		.pclk(pclk), .presetn(presetn),
		.wr_en(access_ph && req.pwrite && hit_pb_low), // RL8
		.wr_data(req.pwdata[7:0]), .value(pb_low_reg)
	);

	// Pin index 0-2 is port A lines 0-2, 3-6 is port B lines 3..0.
	assign codes = {pb_low_reg[`PABFS_FLD_LINE0], pb_low_reg[`PABFS_FLD_LINE1],
		pb_low_reg[`PABFS_FLD_LINE2], pb_low_reg[`PABFS_FLD_LINE3],
		pa_low_reg[`PABFS_FLD_LINE2], pa_low_reg[`PABFS_FLD_LINE1], pa_low_reg[`PABFS_FLD_LINE0]};

	genvar g;
	generate
		for (g = 0; g < 7; g++) begin : g_dec
			pabfs_decode #(.PIN(3'(g))) u_dec (
				.code(codes[2*g+1 -: 2]),
				.sel(dec[g])
			);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= (psel && !penable && !req.pwrite) ? rd_mux : 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_a_line_0_sel <= SEL_RESET;
			port_a_line_1_sel <= SEL_RESET;
			port_a_line_2_sel <= SEL_RESET;
			port_b_line_3_sel <= SEL_RESET;
			port_b_line_2_sel <= SEL_RESET;
			port_b_line_1_sel <= SEL_RESET;
			port_b_line_0_sel <= SEL_RESET;
		end else begin
			port_a_line_0_sel <= dec[0]; // RL3
			port_a_line_1_sel <= dec[1]; // RL2
			port_a_line_2_sel <= dec[2]; // RL1
			port_b_line_3_sel <= dec[3]; // RL4
			port_b_line_2_sel <= dec[4]; // RL5
			port_b_line_1_sel <= dec[5]; // RL6
			port_b_line_0_sel <= dec[6]; // RL7
		end
	end

	// Pin functions follow the stored code one edge later.
	sequence pa_low_write_s;
		psel && penable && pready && pwrite && paddr == `PABFS_OFF_PA_LOW;
	endsequence
	sequence pb_low_write_s;
		psel && penable && pready && pwrite && paddr == `PABFS_OFF_PB_LOW;
	endsequence

	pa2_lcd_map_a: assert property (@(posedge pclk) disable iff (!presetn) // RL1
		pa_low_write_s ##0 (pwdata[5:4] == 2'h3) |-> ##2 (port_a_line_2_sel.func == PABFS_FN_LCD
		&& port_a_line_2_sel.lcd_line == 4'h2)) else $error("port A line 2 not on LCD line 2");
	pa2_int_map_a: assert property (@(posedge pclk) disable iff (!presetn) // RL1
		pa_low_write_s ##0 (pwdata[5:4] != 2'h3) |-> ##2 (port_a_line_2_sel.func == PABFS_FN_GPIO_EXT_INTERRUPT_ONE))
		else $error("port A line 2 not on interrupt one");
	pa1_serial_a: assert property (@(posedge pclk) disable iff (!presetn) // RL2
		pa_low_write_s ##0 (pwdata[3:2] == 2'h2) |-> ##2 (port_a_line_1_sel.func == PABFS_FN_SERIAL_OUT))
		else $error("port A line 1 not on serial out");
	pa0_timer_a: assert property (@(posedge pclk) disable iff (!presetn) // RL3
		pa_low_write_s ##0 (pwdata[1:0] == 2'h2) |-> ##2 (port_a_line_0_sel.func == PABFS_FN_STD_TIMER))
		else $error("port A line 0 not on timer out");
	pb3_analog_a: assert property (@(posedge pclk) disable iff (!presetn) // RL4
		pb_low_write_s ##0 (pwdata[7:6] == 2'h3) |-> ##2 (port_b_line_3_sel.func == PABFS_FN_ANALOG
		&& port_b_line_3_sel.analog_chan == 3'h7)) else $error("port B line 3 not on analog 7");
	pb2_clock_a: assert property (@(posedge pclk) disable iff (!presetn) // RL5
		pb_low_write_s ##0 (pwdata[5:4] == 2'h0) |-> ##2 (port_b_line_2_sel.func == PABFS_FN_GPIO_TCK))
		else $error("port B line 2 not on timer clock");
	pb1_crystal_a: assert property (@(posedge pclk) disable iff (!presetn) // RL6
		pb_low_write_s ##0 (pwdata[3:2] == 2'h3) |-> ##2 (port_b_line_1_sel.func == PABFS_FN_CRYSTAL))
		else $error("port B line 1 not on crystal pin");
	pb0_lcd_a: assert property (@(posedge pclk) disable iff (!presetn) // RL7
		pb_low_write_s ##0 (pwdata[1:0] == 2'h1) |-> ##2 (port_b_line_0_sel.lcd_line == 4'h8
		&& port_b_line_0_sel.func == PABFS_FN_LCD)) else $error("port B line 0 not on LCD line 8");
	reg_readback_a: assert property (@(posedge pclk) disable iff (!presetn) // RL8
		pa_low_write_s |=> (pa_low_reg == $past(pwdata[7:0]))) else $error("select register lost write");

	// Remaining codes of port A line 1.
	pa1_int_a: assert property (@(posedge pclk) disable iff (!presetn) // RL2
		pa_low_write_s ##0 (pwdata[3:2] <= 2'h1) |-> ##2 (port_a_line_1_sel.func == PABFS_FN_GPIO_EXT_INTERRUPT_ZERO))
		else $error("port A line 1 not on interrupt zero");
	pa1_lcd_a: assert property (@(posedge pclk) disable iff (!presetn) // RL2
		pa_low_write_s ##0 (pwdata[3:2] == 2'h3) |-> ##2 (port_a_line_1_sel.func == PABFS_FN_LCD
		&& port_a_line_1_sel.lcd_line == 4'h1)) else $error("port A line 1 not on LCD line 1");

	// Remaining codes of port A line 0.
	pa0_gpio_a: assert property (@(posedge pclk) disable iff (!presetn) // RL3
		pa_low_write_s ##0 (pwdata[1:0] <= 2'h1) |-> ##2 (port_a_line_0_sel.func == PABFS_FN_GPIO))
		else $error("port A line 0 not on plain I/O");
	pa0_lcd_a: assert property (@(posedge pclk) disable iff (!presetn) // RL3
		pa_low_write_s ##0 (pwdata[1:0] == 2'h3) |-> ##2 (port_a_line_0_sel.func == PABFS_FN_LCD
		&& port_a_line_0_sel.lcd_line == 4'h0)) else $error("port A line 0 not on LCD line 0");

	// Remaining codes of port B line 3.
	pb3_gpio_a: assert property (@(posedge pclk) disable iff (!presetn) // RL4
		pb_low_write_s ##0 (pwdata[7:6] == 2'h0) |-> ##2 (port_b_line_3_sel.func == PABFS_FN_GPIO))
		else $error("port B line 3 not on plain I/O");
	pb3_timer_a: assert property (@(posedge pclk) disable iff (!presetn) // RL4
		pb_low_write_s ##0 (pwdata[7:6] == 2'h1) |-> ##2 (port_b_line_3_sel.func == PABFS_FN_CMP_TIMER))
		else $error("port B line 3 not on compact timer");
	pb3_lcd_a: assert property (@(posedge pclk) disable iff (!presetn) // RL4
		pb_low_write_s ##0 (pwdata[7:6] == 2'h2) |-> ##2 (port_b_line_3_sel.func == PABFS_FN_LCD
		&& port_b_line_3_sel.lcd_line == 4'hB)) else $error("port B line 3 not on LCD line 11");

	// Remaining codes of port B line 2.
	pb2_timer_a: assert property (@(posedge pclk) disable iff (!presetn) // RL5
		pb_low_write_s ##0 (pwdata[5:4] == 2'h1) |-> ##2 (port_b_line_2_sel.func == PABFS_FN_STD_TIMER))
		else $error("port B line 2 not on timer out");
	pb2_lcd_a: assert property (@(posedge pclk) disable iff (!presetn) // RL5
		pb_low_write_s ##0 (pwdata[5:4] == 2'h2) |-> ##2 (port_b_line_2_sel.func == PABFS_FN_LCD
		&& port_b_line_2_sel.lcd_line == 4'hA)) else $error("port B line 2 not on LCD line 10");
	pb2_analog_a: assert property (@(posedge pclk) disable iff (!presetn) // RL5
		pb_low_write_s ##0 (pwdata[5:4] == 2'h3) |-> ##2 (port_b_line_2_sel.func == PABFS_FN_ANALOG
		&& port_b_line_2_sel.analog_chan == 3'h2)) else $error("port B line 2 not on analog 2");

	// Remaining codes of port B line 1.
	pb1_int_a: assert property (@(posedge pclk) disable iff (!presetn) // RL6
		pb_low_write_s ##0 (pwdata[3:2] == 2'h0) |-> ##2 (port_b_line_1_sel.func == PABFS_FN_GPIO_EXT_INTERRUPT_ONE))
		else $error("port B line 1 not on interrupt one");
	pb1_lcd_a: assert property (@(posedge pclk) disable iff (!presetn) // RL6
		pb_low_write_s ##0 (pwdata[3:2] == 2'h1) |-> ##2 (port_b_line_1_sel.func == PABFS_FN_LCD
		&& port_b_line_1_sel.lcd_line == 4'h9)) else $error("port B line 1 not on LCD line 9");
	pb1_analog_a: assert property (@(posedge pclk) disable iff (!presetn) // RL6
		pb_low_write_s ##0 (pwdata[3:2] == 2'h2) |-> ##2 (port_b_line_1_sel.func == PABFS_FN_ANALOG
		&& port_b_line_1_sel.analog_chan == 3'h1)) else $error("port B line 1 not on analog 1");

	// Remaining codes of port B line 0; the illegible codes stay on I/O with interrupt zero.
	pb0_int_a: assert property (@(posedge pclk) disable iff (!presetn) // RL7
		pb_low_write_s ##0 (pwdata[1:0] != 2'h1) |-> ##2 (port_b_line_0_sel.func == PABFS_FN_GPIO_EXT_INTERRUPT_ZERO))
		else $error("port B line 0 not on interrupt zero");

	// Storage of the other two registers.
	sequence pa_high_write_s;
		psel && penable && pready && pwrite && paddr == `PABFS_OFF_PA_HIGH;
	endsequence
	sequence unmapped_write_s;
		psel && penable && pready && pwrite && !mapped;
	endsequence
	pb_readback_a: assert property (@(posedge pclk) disable iff (!presetn) // RL8
		pb_low_write_s |=> (pb_low_reg == $past(pwdata[7:0]))) else $error("port B register lost write");
	pa_high_readback_a: assert property (@(posedge pclk) disable iff (!presetn) // RL8
		pa_high_write_s |=> (pa_high_reg == $past(pwdata[7:0]))) else $error("port A high register lost write");
	stray_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RL8
		unmapped_write_s |=> ($stable(pa_low_reg) && $stable(pa_high_reg) && $stable(pb_low_reg)))
		else $error("unmapped write changed a register");

	// Bus answer: one access cycle, no wait states, error and data only with ready.
	sequence setup_s;
		psel && !penable;
	endsequence
	ready_after_setup_a: assert property (@(posedge pclk) disable iff (!presetn) // RL8
		setup_s |=> pready) else $error("no ready after setup");
	ready_alone_a: assert property (@(posedge pclk) disable iff (!presetn) // RL8
		!(psel && !penable) |=> !pready) else $error("ready outside access phase");
	err_with_ready_a: assert property (@(posedge pclk) disable iff (!presetn) // RL8
		pslverr |-> pready) else $error("error without ready");
	err_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn) // RL8
		setup_s ##0 !mapped |=> pslverr) else $error("unmapped access without error");
	err_mapped_a: assert property (@(posedge pclk) disable iff (!presetn) // RL8
		setup_s ##0 mapped |=> !pslverr) else $error("mapped access with error");
	rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // RL8
		!pready |-> (prdata == 32'h00000000)) else $error("read data outside access");
	rdata_upper_a: assert property (@(posedge pclk) disable iff (!presetn) // RL8
		prdata[31:8] == 24'h000000) else $error("read data above bit 7");
	rdata_value_a: assert property (@(posedge pclk) disable iff (!presetn) // RL8
		setup_s ##0 !pwrite ##0 (paddr == `PABFS_OFF_PB_LOW) |=> (prdata == {24'h000000, pb_low_reg}))
		else $error("read data not the port B register");
endmodule
`default_nettype wire

/* verification/pabfs_tb.sv */
// Self-checking APB testbench for the port A/B function select block.
`timescale 1ns/10ps
`default_nettype none
`include "pabfs_regs.svh"
module tb;
	import pabfs_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	pabfs_pin_sel_t sel [7];
	pabfs_pin_sel_t exp_tbl [7][4];
	logic [15:0] pats [5] = '{16'h0000, 16'h5555, 16'hAAAA, 16'hFFFF, 16'hE41B};
	logic [31:0] rd;
	logic err;
	int failures = 0;
	int checked = 0;
	int cyc = 0;
	always #10 pclk = ~pclk;
	pabfs_top pabfs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_a_line_0_sel(sel[0]), .port_a_line_1_sel(sel[1]),
		.port_a_line_2_sel(sel[2]), .port_b_line_0_sel(sel[3]), .port_b_line_1_sel(sel[4]),
		.port_b_line_2_sel(sel[5]), .port_b_line_3_sel(sel[6]));
	function automatic pabfs_pin_sel_t s(pabfs_func_t f, logic [3:0] l, logic [2:0] a);
		s = '{f, l, a};
	endfunction
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One APB transfer; the request is held until pready is sampled high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// The answer is looked at mid-cycle, where it has settled, and the transfer ends at the next rising edge.
		do begin
			@(negedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			chk("pready", 32'h0, 32'h1);
		end
		rd = prdata;
		err = pslverr;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
		apb(1'b0, a, 32'h0);
		chk("prdata", rd, exp);
		chk("pslverr", {31'h0, err}, {31'h0, exp_err});
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			conclude();
		end
	end
	initial begin
		exp_tbl[0] = '{s(PABFS_FN_GPIO, 0, 0), s(PABFS_FN_GPIO, 0, 0), s(PABFS_FN_STD_TIMER, 0, 0), s(PABFS_FN_LCD, 0, 0)};
		exp_tbl[1] = '{s(PABFS_FN_GPIO_EXT_INTERRUPT_ZERO, 0, 0), s(PABFS_FN_GPIO_EXT_INTERRUPT_ZERO, 0, 0), s(PABFS_FN_SERIAL_OUT, 0, 0),
			s(PABFS_FN_LCD, 1, 0)};
		exp_tbl[2] = '{s(PABFS_FN_GPIO_EXT_INTERRUPT_ONE, 0, 0), s(PABFS_FN_GPIO_EXT_INTERRUPT_ONE, 0, 0), s(PABFS_FN_GPIO_EXT_INTERRUPT_ONE, 0, 0),
			s(PABFS_FN_LCD, 2, 0)};
		exp_tbl[3] = '{s(PABFS_FN_GPIO_EXT_INTERRUPT_ZERO, 0, 0), s(PABFS_FN_LCD, 8, 0), s(PABFS_FN_GPIO_EXT_INTERRUPT_ZERO, 0, 0),
			s(PABFS_FN_GPIO_EXT_INTERRUPT_ZERO, 0, 0)};
		exp_tbl[4] = '{s(PABFS_FN_GPIO_EXT_INTERRUPT_ONE, 0, 0), s(PABFS_FN_LCD, 9, 0), s(PABFS_FN_ANALOG, 0, 1),
			s(PABFS_FN_CRYSTAL, 0, 0)};
		exp_tbl[5] = '{s(PABFS_FN_GPIO_TCK, 0, 0), s(PABFS_FN_STD_TIMER, 0, 0), s(PABFS_FN_LCD, 10, 0),
			s(PABFS_FN_ANALOG, 0, 2)};
		exp_tbl[6] = '{s(PABFS_FN_GPIO, 0, 0), s(PABFS_FN_CMP_TIMER, 0, 0), s(PABFS_FN_LCD, 11, 0),
			s(PABFS_FN_ANALOG, 0, 7)};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(`PABFS_OFF_PA_LOW, 32'h0, 1'b0);
		rd_chk(`PABFS_OFF_PA_HIGH, 32'h0, 1'b0);
		rd_chk(`PABFS_OFF_PB_LOW, 32'h0, 1'b0);
		foreach (pats[p]) begin
			apb(1'b1, `PABFS_OFF_PA_LOW, {24'hFFFFFF, pats[p][15:8]});
			apb(1'b1, `PABFS_OFF_PB_LOW, {24'h0, pats[p][7:0]});
			rd_chk(`PABFS_OFF_PA_LOW, {24'h0, pats[p][15:8]}, 1'b0);
			rd_chk(`PABFS_OFF_PB_LOW, {24'h0, pats[p][7:0]}, 1'b0);
			for (int i = 0; i < 7; i++) begin
				chk("pin_sel", {21'h0, sel[i]}, {21'h0, exp_tbl[i][(i < 3) ? pats[p][8 + 2 * i +: 2] : pats[p][2 * (i - 3) +: 2]]});
			end
		end
		apb(1'b1, `PABFS_OFF_PA_HIGH, 32'h000000A5);
		apb(1'b1, 12'h00C, 32'h000000FF);
		rd_chk(`PABFS_OFF_PA_HIGH, 32'hA5, 1'b0);
		rd_chk(12'h00C, 32'h0, 1'b1);
		rd_chk(`PABFS_OFF_PB_LOW, 32'h1B, 1'b0);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(`PABFS_OFF_PA_HIGH, 32'h0, 1'b0);
		rd_chk(`PABFS_OFF_PB_LOW, 32'h0, 1'b0);
		chk("pin_sel", {21'h0, sel[5]}, {21'h0, exp_tbl[5][0]});
		conclude();
	end
endmodule
`default_nettype wire
